//--- ready_wait_pkg.sv
/*
  Package for the external bus ready wait control block: register offsets,
  field layouts, reset values, cycle phase states and carrier structs.
  Assumes a single 200 MHz clock and a plain strobe register port.
*/
`default_nettype none

package ready_wait_pkg;

  // ****************************************
  // clock and register map
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;          // 200 MHz core clock
  localparam int REG_ADDR_W    = 4;
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] TIMING_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_W   = 3;
  localparam int TIMING_W = 13;
  localparam int WAIT_W   = 8;
  localparam int STATUS_WAIT_LSB = 8;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;       // ready off, low active, sync
  localparam logic [12:0] TIMING_RESET = 13'h0001;   // one address setup period

  // control register: bit2 ready enable, bit1 active high, bit0 async mode
  typedef struct packed {
    logic readyEn;
    logic activeHigh;
    logic asyncMode;
  } ctrl_t;

  // timing register, all figures in reference clock periods
  typedef struct packed {
    logic [1:0] addrSetup;     // 1..3, a zero reads as one
    logic [1:0] windowExtra;   // 0..3 added on window change
    logic [1:0] cmdDelay;      // 0..3
    logic [4:0] accessM1;      // access phase length minus one (1..32)
    logic [1:0] hold;          // 0..3
  } timing_t;

  // cycle phases
  typedef enum logic [4:0] {
    IDLE   = 5'b00001,
    ADDR   = 5'b00010,
    CMD    = 5'b00100,
    ACCESS = 5'b01000,
    HOLD   = 5'b10000
  } phase_t;

endpackage : ready_wait_pkg

`default_nettype wire

//--- ready_input_sync.sv
/*
  Three flop pin synchroniser with agreement filter for the ready pin.
  Assumes the pin is asynchronous to clk; the filtered level changes only
  once the second and third flops agree.
*/
`timescale 1ns/1ps
`default_nettype none

module ready_input_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output var  logic level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ****************************************
  // synchroniser chain
  // ****************************************
  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'h0;
      stage2 <= 1'h0;
      stage3 <= 1'h0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // level follows once second and third agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 1'h0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

endmodule : ready_input_sync

`default_nettype wire

//--- ready_wait_ctrl.sv
/*
  External bus cycle sequencer with ready controlled wait states.
  Assumes a requester on the same clock and an external circuit driving the
  ready pin; the reference clock out is derived from clk by a divider.
*/
// Local design decisions: the register offsets and the address-and-strobe port.
// Behaviour
// - Software picks the ready pin polarity and whether ready ends or stretches each cycle.
// - Asynchronous mode adds a sync stage so each ready cycle gets at least one wait state.
// - The first ready sample point follows from the programmed phase lengths.
// - Ready seen inactive at a sample point inserts one wait state and samples again.
// - Ready seen active at a sample point ends the running cycle.
// - Asynchronous sampling happens one reference period before the decision point.
// - Mandatory access phase periods run out before ready is first evaluated.
// - Read data are captured on the edge that raises the read strobe.
// - Address setup lasts one or two periods and grows when the window changes; the code also gives three for a setup field of 3.
`timescale 1ns/1ps
`default_nettype none

module ready_wait_ctrl #(
  parameter int ADDR_W      = 24,
  parameter int DATA_W      = 16,
  parameter int WIN_W       = 3,
  parameter int CLK_PER_TCS = 2
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [ready_wait_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]                          regWdata,
  input  wire logic                                 regWrite,
  input  wire logic                                 regRead,
  output var  logic [31:0]                          regRdata,
  input  wire logic                                 reqValid,
  input  wire logic                                 reqWrite,
  input  wire logic [ADDR_W-1:0]                    reqAddr,
  input  wire logic [DATA_W-1:0]                    reqWdata,
  input  wire logic [WIN_W-1:0]                     reqWindow,
  output var  logic                                 reqReady,
  output var  logic                                 cycleDone,
  output var  logic [DATA_W-1:0]                    readData,
  output var  logic                                 busRefClk,
  output var  logic [ADDR_W-1:0]                    busAddr,
  output var  logic                                 busReadN,
  output var  logic                                 busWriteN,
  output var  logic [DATA_W-1:0]                    busDataOut,
  output var  logic                                 busDataOe,
  input  wire logic [DATA_W-1:0]                    busDataIn,
  input  wire logic                                 readyPin
);

  localparam int DIV_W = $clog2(CLK_PER_TCS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_TCS - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CLK_PER_TCS / 2);

  ready_wait_pkg::ctrl_t       ctrl;
  ready_wait_pkg::timing_t     timing;
  ready_wait_pkg::phase_t      phase;
  logic [DIV_W-1:0]            divCnt;
  logic                        tick;
  logic [5:0]                  phaseCnt;
  logic                        readyLevel;
  logic                        rdyNow;
  logic                        asyncStage;
  logic                        rdyGo;
  logic                        evalPoint;
  logic                        accessEnd;
  logic                        curWrite;
  logic [WIN_W-1:0]            lastWindow;
  logic                        windowValid;
  logic [5:0]                  addrLen;
  logic [ready_wait_pkg::WAIT_W-1:0] waitCnt;
  logic [ready_wait_pkg::WAIT_W-1:0] lastWaits;
  logic                        accept;

  // ****************************************
  // reference clock divider
  // ****************************************
  // tick marks the clk edge that raises the reference clock
  assign tick = (divCnt == DIV_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt    <= '0;
      busRefClk <= 1'h0;
    end else begin
      divCnt    <= tick ? '0 : divCnt + DIV_W'(1);
      busRefClk <= tick || ((divCnt + DIV_W'(1)) < DIV_HALF);
    end
  end

  // ****************************************
  // ready input path
  // ****************************************
  ready_input_sync u_ready_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (readyPin),
    .level (readyLevel)
  );

  assign rdyNow = readyLevel ^ ~ctrl.activeHigh;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asyncStage <= 1'h0;
    end else if (tick) begin
      asyncStage <= rdyNow;
    end
  end

  assign rdyGo = ctrl.asyncMode ? (asyncStage && waitCnt != '0) : rdyNow;

  assign evalPoint = tick && phase == ready_wait_pkg::ACCESS && phaseCnt == '0;
  assign accessEnd = evalPoint && (!ctrl.readyEn || rdyGo);
  assign accept    = reqValid && reqReady && tick;

  // setup length with window change extension
  always_comb begin
    addrLen = (timing.addrSetup == 2'h0) ? 6'h01 : {4'h0, timing.addrSetup};
    if (windowValid && reqWindow != lastWindow) begin
      addrLen = addrLen + {4'h0, timing.windowExtra};
    end
  end

  // ****************************************
  // phase sequencer
  // ****************************************
  // phase lengths place the first sample point
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase    <= ready_wait_pkg::IDLE;
      phaseCnt <= '0;
    end else if (tick) begin
      unique case (phase)
        ready_wait_pkg::IDLE: begin
          if (accept) begin
            phase    <= ready_wait_pkg::ADDR;
            phaseCnt <= addrLen - 6'h01;
          end
        end
        ready_wait_pkg::ADDR: begin
          if (phaseCnt != '0) begin
            phaseCnt <= phaseCnt - 6'h01;
          end else if (timing.cmdDelay != 2'h0) begin
            phase    <= ready_wait_pkg::CMD;
            phaseCnt <= {4'h0, timing.cmdDelay} - 6'h01;
          end else begin
            phase    <= ready_wait_pkg::ACCESS;
            phaseCnt <= {1'h0, timing.accessM1};
          end
        end
        ready_wait_pkg::CMD: begin
          if (phaseCnt != '0) begin
            phaseCnt <= phaseCnt - 6'h01;
          end else begin
            phase    <= ready_wait_pkg::ACCESS;
            phaseCnt <= {1'h0, timing.accessM1};
          end
        end
        ready_wait_pkg::ACCESS: begin
          if (phaseCnt != '0) begin
            phaseCnt <= phaseCnt - 6'h01;
          end else if (accessEnd && timing.hold != 2'h0) begin
            phase    <= ready_wait_pkg::HOLD;
            phaseCnt <= {4'h0, timing.hold} - 6'h01;
          end else if (accessEnd) begin
            phase    <= ready_wait_pkg::IDLE;
          end
        end
        ready_wait_pkg::HOLD: begin
          if (phaseCnt != '0) begin
            phaseCnt <= phaseCnt - 6'h01;
          end else begin
            phase    <= ready_wait_pkg::IDLE;
          end
        end
      endcase
    end
  end

  // inactive ready adds one wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitCnt   <= '0;
      lastWaits <= '0;
    end else if (accept) begin
      waitCnt <= '0;
    end else if (accessEnd) begin
      lastWaits <= waitCnt;
    end else if (evalPoint && waitCnt != '1) begin
      waitCnt <= waitCnt + 8'h01;
    end
  end

  // ****************************************
  // bus pins and requester answer
  // ****************************************
  // request latch and window memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      curWrite    <= 1'h0;
      busAddr     <= '0;
      busDataOut  <= '0;
      lastWindow  <= '0;
      windowValid <= 1'h0;
    end else if (accept) begin
      curWrite    <= reqWrite;
      busAddr     <= reqAddr;
      busDataOut  <= reqWdata;
      lastWindow  <= reqWindow;
      windowValid <= 1'h1;
    end
  end

  // strobes, data enable, done pulse and read capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busReadN  <= 1'h1;
      busWriteN <= 1'h1;
      busDataOe <= 1'h0;
      cycleDone <= 1'h0;
      readData  <= '0;
      reqReady  <= 1'h0;
    end else begin
      cycleDone <= accessEnd;
      reqReady  <= (phase == ready_wait_pkg::IDLE) && !accept;
      if (accept) begin
        busDataOe <= reqWrite;
      end else if (tick && phase == ready_wait_pkg::HOLD && phaseCnt == '0) begin
        busDataOe <= 1'h0;
      end else if (accessEnd && timing.hold == 2'h0) begin
        busDataOe <= 1'h0;
      end
      if (tick && phase != ready_wait_pkg::ACCESS && phaseCnt == '0 &&
          (phase == ready_wait_pkg::CMD ||
           (phase == ready_wait_pkg::ADDR && timing.cmdDelay == 2'h0))) begin
        busReadN  <= curWrite;
        busWriteN <= !curWrite;
      end else if (accessEnd) begin
        busReadN  <= 1'h1;
        busWriteN <= 1'h1;
      end
      if (accessEnd && !curWrite) begin
        readData <= busDataIn;
      end
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // control and timing writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl   <= ready_wait_pkg::CTRL_RESET;
      timing <= ready_wait_pkg::TIMING_RESET;
    end else if (regWrite && regAddr == ready_wait_pkg::CTRL_OFFSET) begin
      ctrl <= regWdata[ready_wait_pkg::CTRL_W-1:0];
    end else if (regWrite && regAddr == ready_wait_pkg::TIMING_OFFSET) begin
      timing <= regWdata[ready_wait_pkg::TIMING_W-1:0];
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        ready_wait_pkg::CTRL_OFFSET:   regRdata <= {29'h0, ctrl};
        ready_wait_pkg::TIMING_OFFSET: regRdata <= {19'h0, timing};
        ready_wait_pkg::STATUS_OFFSET: regRdata <= {16'h0, lastWaits, 6'h0, rdyNow,
                                                    phase != ready_wait_pkg::IDLE};
        default:                       regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] accTicks;
  logic [5:0] addrTicks;
  logic [5:0] addrExpect;
  logic       tickSeen;

  // helper counters of periods spent in access and address phases
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accTicks   <= '0;
      addrTicks  <= '0;
      addrExpect <= '0;
      tickSeen   <= 1'h0;
    end else begin
      tickSeen <= tick;
      if (accept) begin
        addrExpect <= addrLen;
        addrTicks  <= '0;
      end else if (tick && phase == ready_wait_pkg::ADDR) begin
        addrTicks <= addrTicks + 6'h01;
      end
      if (phase != ready_wait_pkg::ACCESS) begin
        accTicks <= '0;
      end else if (tick && accTicks != '1) begin
        accTicks <= accTicks + 6'h01;
      end
    end
  end

  polarity_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdyNow == (ctrl.activeHigh ? readyLevel : !readyLevel))
    else $error("ready polarity not applied");

  async_min_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    accessEnd && ctrl.readyEn && ctrl.asyncMode |=> lastWaits != '0)
    else $error("async ready cycle ended without a wait state");

  sample_point_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(phase == ready_wait_pkg::ACCESS) |-> phaseCnt == {1'h0, timing.accessM1})
    else $error("first sample point not from access length");

  wait_inserted_a: assert property (@(posedge clk) disable iff (!rst_n)
    evalPoint && ctrl.readyEn && !rdyGo |=> phase == ready_wait_pkg::ACCESS && !tick
      ##(CLK_PER_TCS - 1) evalPoint)
    else $error("inactive ready did not add one wait state");

  ready_ends_a: assert property (@(posedge clk) disable iff (!rst_n)
    evalPoint && rdyGo |=> phase != ready_wait_pkg::ACCESS && busReadN && busWriteN && cycleDone)
    else $error("active ready did not end the cycle");

  async_early_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> asyncStage == $past(rdyNow))
    else $error("async stage not sampled at the earlier edge");

  // only the first evaluation of a cycle follows the mandatory periods directly
  mandatory_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    evalPoint && waitCnt == '0 |-> accTicks == {1'h0, timing.accessM1})
    else $error("ready evaluated before mandatory periods ran out");

  read_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    accessEnd && !curWrite |=> readData == $past(busDataIn) && $rose(busReadN))
    else $error("read data not captured on strobe rise");

  addr_setup_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(phase == ready_wait_pkg::ADDR) |-> addrTicks == addrExpect)
    else $error("address setup length wrong");

  rising_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
    evalPoint |=> busRefClk && tickSeen)
    else $error("ready not sampled on reference clock rise");

endmodule : ready_wait_ctrl

`default_nettype wire

//--- ext_ready_device.sv
/*
  Model of the external circuit on the far side of the bus: it answers read
  cycles with data and drives the ready pin after a chosen number of periods.
  Assumes the reference clock and strobes of the ready wait control block.
*/
`timescale 1ns/1ps
`default_nettype none

module ext_ready_device (
  input  wire logic        clk,
  input  wire logic        busRefClk,
  input  wire logic        busReadN,
  input  wire logic        busWriteN,
  input  wire logic [23:0] busAddr,
  input  wire logic        activeHigh,
  input  wire logic [7:0]  delayPeriods,
  output var  logic [15:0] busDataIn,
  output var  logic        readyPin
);
  logic       prevRef  = 1'b0;
  logic [7:0] cnt      = 8'h00;
  logic       asserted = 1'b0;

  // ****************************************
  // ready generation
  // ****************************************
  // withdraw once the strobe rises
  always @(posedge clk) begin
    prevRef <= busRefClk;
    if (busReadN && busWriteN) begin
      cnt      <= 8'h00;
      asserted <= 1'b0;
    end else if (busRefClk && !prevRef) begin
      // change with the reference clock, hold to strobe end
      if (cnt >= delayPeriods) asserted <= 1'b1;
      else cnt <= cnt + 8'h01;
    end
  end

  // chosen polarity on the pin
  assign readyPin = asserted ? activeHigh : !activeHigh;

  // read data while selected, a toggling pattern once released
  always @(posedge clk) begin
    if (!busReadN) busDataIn <= busAddr[15:0] ^ 16'h5a5a;
    else busDataIn <= ~busDataIn;
  end

  initial busDataIn = 16'h0000;
endmodule : ext_ready_device

`default_nettype wire

//--- tb_top.sv
/*
  Testbench for the ready wait control block: register port, plain and
  ready controlled bus cycles, both ready modes, polarity and window change.
  Assumes the external device model and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int CPT = 2;
  logic        clk = 1'b0;
  logic        rst_n;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        reqValid;
  logic        reqWrite;
  logic [23:0] reqAddr;
  logic [15:0] reqWdata;
  logic [2:0]  reqWindow;
  logic        reqReady;
  logic        cycleDone;
  logic [15:0] readData;
  logic        busRefClk;
  logic [23:0] busAddr;
  logic        busReadN;
  logic        busWriteN;
  logic [15:0] busDataOut;
  logic        busDataOe;
  logic [15:0] busDataIn;
  logic        readyPin;
  logic        activeHigh;
  logic [7:0]  delayPeriods;
  int          badCount = 0;
  int          testsRun = 0;
  int          w;

  ready_wait_ctrl #(.CLK_PER_TCS(CPT)) u_ready_wait_ctrl (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqWindow(reqWindow), .reqReady(reqReady),
    .cycleDone(cycleDone), .readData(readData), .busRefClk(busRefClk), .busAddr(busAddr),
    .busReadN(busReadN), .busWriteN(busWriteN), .busDataOut(busDataOut), .busDataOe(busDataOe),
    .busDataIn(busDataIn), .readyPin(readyPin));

  ext_ready_device u_ext_ready_device (
    .clk(clk), .busRefClk(busRefClk), .busReadN(busReadN), .busWriteN(busWriteN),
    .busAddr(busAddr), .activeHigh(activeHigh), .delayPeriods(delayPeriods),
    .busDataIn(busDataIn), .readyPin(readyPin));

  // ****************************************
  // clock
  // ****************************************
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report;
    if (badCount == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      badCount++;
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : reg_rd

  function automatic logic [31:0] tim(int as, int we, int cd, int am1, int hd);
    return {19'h0, as[1:0], we[1:0], cd[1:0], am1[4:0], hd[1:0]};
  endfunction : tim

  // one bus cycle: take, duration, strobe length, data; w returns wait states
  task automatic bus_cycle(input logic wr, input logic [23:0] a, input logic [2:0] win,
                           input int fixP, input int eP, output int w);
    int          n;
    int          low;
    logic        rdy;
    logic        rc;
    logic [31:0] st;
    n   = 0;
    low = 0;
    rdy = 1'b0;
    rc  = 1'b1;
    @(posedge clk);
    reqValid  <= 1'b1;
    reqWrite  <= wr;
    reqAddr   <= a;
    reqWdata  <= a[15:0] ^ 16'h0f0f;
    reqWindow <= win;
    while (!(rdy === 1'b1 && rc === 1'b0)) begin
      @(negedge clk);
      rdy = reqReady;
      rc  = busRefClk;
      @(posedge clk);
      n++;
      if (n > 400) begin
        badCount++;
        final_report();
      end
    end
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (busReadN === 1'b0 || busWriteN === 1'b0) begin
        low++;
        if (low == 1) begin
          chk("busAddr", {8'h0, a}, {8'h0, busAddr});
          chk("busDataOe", {31'h0, wr}, {31'h0, busDataOe});
          if (wr) chk("busDataOut", {16'h0, a[15:0] ^ 16'h0f0f}, {16'h0, busDataOut});
        end
      end
    end while (cycleDone !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      badCount++;
      final_report();
    end
    reg_rd(ready_wait_pkg::STATUS_OFFSET, st);
    w = int'(st[15:8]);
    // done pulse is first seen at the falling edge after the ending edge
    chk("cycle clocks", 32'((fixP + w) * CPT + 1), 32'(n));
    chk("strobe clocks", 32'((eP + w) * CPT), 32'(low));
    if (!wr) chk("readData", {16'h0, a[15:0] ^ 16'h5a5a}, {16'h0, readData});
  endtask : bus_cycle

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] d;
    reg_rd(ready_wait_pkg::CTRL_OFFSET, d);
    chk("ctrl reset", 32'h0, d);
    reg_rd(ready_wait_pkg::TIMING_OFFSET, d);
    chk("timing reset", 32'h1, d);
    reg_wr(4'hc, 32'hffff_ffff);
    reg_rd(4'hc, d);
    chk("unmapped", 32'h0, d);
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h7);
    reg_rd(ready_wait_pkg::CTRL_OFFSET, d);
    chk("ctrl rw", 32'h7, d);
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h0);
  endtask : t_regs

  task automatic t_plain;
    reg_wr(ready_wait_pkg::TIMING_OFFSET, tim(1, 0, 0, 1, 1));
    bus_cycle(1'b0, 24'h000123, 3'h0, 3, 2, w);
    chk("plain waits", 32'h0, 32'(w));
    bus_cycle(1'b1, 24'h00abcd, 3'h0, 3, 2, w);
  endtask : t_plain

  task automatic t_sync;
    reg_wr(ready_wait_pkg::TIMING_OFFSET, tim(1, 0, 1, 7, 0));
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h6);
    delayPeriods <= 8'h00;
    bus_cycle(1'b0, 24'h001111, 3'h0, 10, 8, w);
    chk("sync prompt waits", 32'h0, 32'(w));
    delayPeriods <= 8'h0a;
    bus_cycle(1'b1, 24'h002222, 3'h0, 10, 8, w);
    // late ready must add between three and six wait states
    chk("sync slow waits in 3..6", 32'h1, {31'h0, (w >= 3 && w <= 6)});
  endtask : t_sync

  task automatic t_async;
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h7);
    delayPeriods <= 8'h00;
    bus_cycle(1'b0, 24'h003333, 3'h0, 10, 8, w);
    chk("async waits", 32'h1, 32'(w));
  endtask : t_async

  task automatic t_polarity;
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h4);
    activeHigh <= 1'b0;
    bus_cycle(1'b0, 24'h004444, 3'h0, 10, 8, w);
    chk("low active waits", 32'h0, 32'(w));
    activeHigh <= 1'b1;
  endtask : t_polarity

  task automatic t_window;
    reg_wr(ready_wait_pkg::CTRL_OFFSET, 32'h0);
    reg_wr(ready_wait_pkg::TIMING_OFFSET, tim(2, 2, 0, 0, 0));
    bus_cycle(1'b0, 24'h005555, 3'h0, 3, 1, w);
    bus_cycle(1'b0, 24'h006666, 3'h5, 5, 1, w);
    bus_cycle(1'b1, 24'h007777, 3'h5, 3, 1, w);
  endtask : t_window

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n        = 1'b0;
    regAddr      = 4'h0;
    regWdata     = 32'h0;
    regWrite     = 1'b0;
    regRead      = 1'b0;
    reqValid     = 1'b0;
    reqWrite     = 1'b0;
    reqAddr      = 24'h0;
    reqWdata     = 16'h0;
    reqWindow    = 3'h0;
    activeHigh   = 1'b1;
    delayPeriods = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_plain();
    t_sync();
    t_async();
    t_polarity();
    t_window();
    final_report();
  end
endmodule : tb_top

`default_nettype wire
